// ### design/cprs_map.vh
// Constants for the CPU programmer register set: bus offsets, field
// positions, reset values, command codes and the stack window.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CPRS_MAP_VH
`define CPRS_MAP_VH

// ----------------------------------------
// Memory-mapped register offsets
// ----------------------------------------
`define CPRS_PAGE_BASE_ADDR 16'h003d

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPRS_PAGE_BASE_RESET 8'h00
`define CPRS_FLAGS_RESET 5'h08
`define CPRS_PC_RESET 16'h0000

// ----------------------------------------
// Stack window (127 bytes: 42 call frames or 21 interrupt frames)
// ----------------------------------------
`define CPRS_SP_TOP 16'h017f
`define CPRS_SP_LOW 16'h0101
`define CPRS_CALL_FRAME 3'h3
`define CPRS_INT_FRAME 3'h6

// ----------------------------------------
// Condition flags field positions
// ----------------------------------------
`define CPRS_FLG_C 0
`define CPRS_FLG_Z 1
`define CPRS_FLG_N 2
`define CPRS_FLG_I 3
`define CPRS_FLG_H 4
`define CPRS_FLAGS_PAD 3'h7

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CPRS_OP_NOP 4'h0
`define CPRS_OP_LDA 4'h1
`define CPRS_OP_LDX 4'h2
`define CPRS_OP_ALU_A 4'h3
`define CPRS_OP_ALU_X 4'h4
`define CPRS_OP_LDCC 4'h5
`define CPRS_OP_SEI 4'h6
`define CPRS_OP_CLI 4'h7
`define CPRS_OP_RSP 4'h8
`define CPRS_OP_JMP 4'h9
`define CPRS_OP_BTB 4'ha
`define CPRS_OP_CALL 4'hb
`define CPRS_OP_RTS 4'hc
`define CPRS_OP_RTI 4'hd
`define CPRS_OP_SWI 4'he

// ----------------------------------------
// ALU function codes
// ----------------------------------------
`define CPRS_FN_ADD 3'h0
`define CPRS_FN_ADC 3'h1
`define CPRS_FN_SUB 3'h2
`define CPRS_FN_AND 3'h3
`define CPRS_FN_ORA 3'h4
`define CPRS_FN_EOR 3'h5
`define CPRS_FN_LSL 3'h6
`define CPRS_FN_LSR 3'h7

// ----------------------------------------
// Address modes
// ----------------------------------------
`define CPRS_EA_NONE 2'h0
`define CPRS_EA_INDEXED 2'h1
`define CPRS_EA_DIRECT 2'h2

`endif

// ### design/cprs_alu.v
// Eight-bit arithmetic and logic unit with half-carry and carry results.
// Purely combinational; the caller decides which flags to commit.
`timescale 1ns/1ps
`include "cprs_map.vh"

module cprs_alu (
    input wire [2:0] fn,
    input wire [7:0] a,
    input wire [7:0] b,
    input wire cin,
    output reg [7:0] res,
    output reg h,
    output reg c,
    output reg c_upd,
    output reg h_upd
);

    wire cin_eff = (fn == `CPRS_FN_ADC) ? cin : 1'b0;
    wire [4:0] lo5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin_eff};
    wire [8:0] sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin_eff};
    wire [8:0] diff9 = {1'b0, a} - {1'b0, b};

    // Function select; logical operations leave carry alone
    always @*
    begin
        res = a;
        h = 1'b0;
        c = 1'b0;
        c_upd = 1'b0;
        h_upd = 1'b0;
        case (fn)
            `CPRS_FN_ADD, `CPRS_FN_ADC:
            begin
                res = sum9[7:0];
                c = sum9[8];
                c_upd = 1'b1;
                h = lo5[4];
                h_upd = 1'b1;
            end
            `CPRS_FN_SUB:
            begin
                res = diff9[7:0];
                c = diff9[8];
                c_upd = 1'b1;
            end
            `CPRS_FN_AND: res = a & b;
            `CPRS_FN_ORA: res = a | b;
            `CPRS_FN_EOR: res = a ^ b;
            `CPRS_FN_LSL:
            begin
                res = {a[6:0], 1'b0};
                c = a[7];
                c_upd = 1'b1;
            end
            default:
            begin
                res = {1'b0, a[7:1]};
                c = a[0];
                c_upd = 1'b1;
            end
        endcase
    end

endmodule

// ### design/cprs_addr.v
// Effective address former for indexed and direct addressing.
// Combinational; the top module registers its result.
`timescale 1ns/1ps
`include "cprs_map.vh"

module cprs_addr (
    input wire [1:0] mode,
    input wire [7:0] idx,
    input wire [15:0] offset,
    input wire [7:0] page_base,
    input wire [7:0] operand,
    input wire rm_instr,
    output reg [15:0] ea
);

    // Index is unsigned, so it is zero extended before the add
    always @*
    begin
        case (mode)
            `CPRS_EA_INDEXED: ea = offset + {8'h00, idx};
            `CPRS_EA_DIRECT: ea = {(rm_instr ? 8'h00 : page_base), operand};
            default: ea = offset;
        endcase
    end

endmodule

// ### design/cprs_top.v
// CPU programmer register set: accumulator, index, program counter, stack
// pointer, page base and condition flags, with stack frame sequencing.
// Assumes a sequencer on clk_sys issues commands and a RAM answers stack reads
// in the same cycle as the read strobe.
`timescale 1ns/1ps
`include "cprs_map.vh"

module cprs_top (
    input wire clk_sys,
    input wire rst_n,
    input wire op_valid,
    input wire [3:0] op,
    input wire [2:0] alu_fn,
    input wire [7:0] operand,
    input wire [15:0] offset,
    input wire [1:0] ea_mode,
    input wire rm_instr,
    input wire pc_inc,
    input wire instr_done,
    input wire irq_in,
    input wire nmi_in,
    input wire [15:0] irq_vector,
    input wire [15:0] nmi_vector,
    input wire [15:0] swi_vector,
    input wire [15:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_wdata,
    output reg [7:0] bus_rdata,
    output reg bus_ack,
    input wire [7:0] stk_rdata,
    output reg [15:0] stk_addr,
    output reg [7:0] stk_wdata,
    output reg stk_we,
    output reg stk_re,
    output reg [7:0] acc,
    output reg [7:0] idx,
    output reg [15:0] pc,
    output reg [15:0] sp,
    output reg [7:0] page_base,
    output reg [4:0] flags,
    output reg [15:0] ea,
    output reg busy,
    output reg seq_done
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg [1:0] rst_pipe;
    wire rst_ok = rst_pipe[1];

    // Release is synchronised so every flop leaves reset on the same edge
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe <= 2'b00;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end

    // ----------------------------------------
    // Datapath helpers
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_PUSH = 2'h1;
    localparam ST_POPREQ = 2'h2;
    localparam ST_POPCAP = 2'h3;

    reg [1:0] state;
    reg [2:0] step;
    reg [2:0] frame_len;
    reg seq_int;
    reg [15:0] seq_target;
    reg irq_pend;
    reg nmi_pend;
    reg cli_shadow;
    reg [7:0] push_byte;
    reg [2:0] pop_slot;

    wire alu_on_x = (op == `CPRS_OP_ALU_X);
    wire [7:0] alu_res;
    wire alu_h;
    wire alu_c;
    wire alu_c_upd;
    wire alu_h_upd;
    wire [15:0] ea_next;

    cprs_alu cprs_alu_inst (
        .fn(alu_fn),
        .a(alu_on_x ? idx : acc),
        .b(operand),
        .cin(flags[`CPRS_FLG_C]),
        .res(alu_res),
        .h(alu_h),
        .c(alu_c),
        .c_upd(alu_c_upd),
        .h_upd(alu_h_upd)
    );

    cprs_addr cprs_addr_inst (
        .mode(ea_mode),
        .idx(idx),
        .offset(offset),
        .page_base(page_base),
        .operand(operand),
        .rm_instr(rm_instr),
        .ea(ea_next)
    );

    // Wrap at the window edges so a runaway stack never leaves its page
    wire [15:0] sp_dec = (sp == `CPRS_SP_LOW) ? `CPRS_SP_TOP : sp - 16'h0001;
    wire [15:0] sp_inc = (sp == `CPRS_SP_TOP) ? `CPRS_SP_LOW : sp + 16'h0001;
    wire page_hit = (bus_addr == `CPRS_PAGE_BASE_ADDR);
    wire is_cli = op_valid && (state == ST_IDLE) && (op == `CPRS_OP_CLI);
    wire irq_allowed = irq_pend && !flags[`CPRS_FLG_I] && !cli_shadow && !is_cli;
    wire last_step = (step == frame_len - 3'h1);

    // Push order by slot; the flags byte pads the upper bits with ones
    always @*
    begin
        case (step)
            3'h0: push_byte = seq_int ? pc[7:0] : seq_target[7:0];
            3'h1: push_byte = seq_int ? pc[15:8] : seq_target[15:8];
            3'h2: push_byte = page_base;
            3'h3: push_byte = idx;
            3'h4: push_byte = acc;
            default: push_byte = {`CPRS_FLAGS_PAD, flags};
        endcase
    end

    // Popping walks the push slots backwards
    always @*
    begin
        pop_slot = frame_len - 3'h1 - step;
    end

    // ----------------------------------------
    // Register set and frame sequencer
    // ----------------------------------------
    // One process owns every register except the reset pipe, so bus writes, commands and pops
    // never drive the same flop from two places
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc <= 8'h00;
            idx <= 8'h00;
            pc <= `CPRS_PC_RESET;
            sp <= `CPRS_SP_TOP;
            page_base <= `CPRS_PAGE_BASE_RESET;
            flags <= `CPRS_FLAGS_RESET;
            ea <= 16'h0000;
            state <= ST_IDLE;
            step <= 3'h0;
            frame_len <= `CPRS_CALL_FRAME;
            seq_int <= 1'b0;
            seq_target <= 16'h0000;
            irq_pend <= 1'b0;
            nmi_pend <= 1'b0;
            cli_shadow <= 1'b0;
            stk_addr <= 16'h0000;
            stk_wdata <= 8'h00;
            stk_we <= 1'b0;
            stk_re <= 1'b0;
            bus_rdata <= 8'h00;
            bus_ack <= 1'b0;
            busy <= 1'b0;
            seq_done <= 1'b0;
        end
        else if (!rst_ok)
        begin
            sp <= `CPRS_SP_TOP;
            page_base <= `CPRS_PAGE_BASE_RESET;
        end
        else
        begin
            stk_we <= 1'b0;
            stk_re <= 1'b0;
            seq_done <= 1'b0;
            bus_ack <= bus_wr | bus_rd;
            bus_rdata <= (bus_rd && page_hit) ? page_base : 8'h00;
            if (ea_mode != `CPRS_EA_NONE)
                ea <= ea_next;
            if (bus_wr && page_hit)
                page_base <= bus_wdata;
            // Set beats clear: a new request in the serving cycle stays pending
            nmi_pend <= nmi_in | nmi_pend;
            irq_pend <= irq_in | irq_pend;
            if (instr_done && cli_shadow)
                cli_shadow <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (pc_inc)
                        pc <= pc + 16'h0001;
                    if (op_valid)
                    begin
                        case (op)
                            `CPRS_OP_LDA, `CPRS_OP_LDX:
                            begin
                                if (op == `CPRS_OP_LDA)
                                    acc <= operand;
                                else
                                    idx <= operand;
                                flags[`CPRS_FLG_N] <= operand[7];
                                flags[`CPRS_FLG_Z] <= (operand == 8'h00);
                            end
                            `CPRS_OP_ALU_A, `CPRS_OP_ALU_X:
                            begin
                                if (alu_on_x)
                                    idx <= alu_res;
                                else
                                    acc <= alu_res;
                                flags[`CPRS_FLG_N] <= alu_res[7];
                                flags[`CPRS_FLG_Z] <= (alu_res == 8'h00);
                                if (alu_c_upd)
                                    flags[`CPRS_FLG_C] <= alu_c;
                                if (alu_h_upd)
                                    flags[`CPRS_FLG_H] <= alu_h;
                            end
                            `CPRS_OP_LDCC: flags <= operand[4:0];
                            `CPRS_OP_SEI: flags[`CPRS_FLG_I] <= 1'b1;
                            `CPRS_OP_CLI:
                            begin
                                flags[`CPRS_FLG_I] <= 1'b0;
                                cli_shadow <= 1'b1;
                            end
                            `CPRS_OP_RSP: sp <= `CPRS_SP_TOP;
                            `CPRS_OP_JMP: pc <= offset;
                            `CPRS_OP_BTB: flags[`CPRS_FLG_C] <= operand[alu_fn];
                            `CPRS_OP_CALL:
                            begin
                                seq_int <= 1'b0;
                                frame_len <= `CPRS_CALL_FRAME;
                                seq_target <= pc;
                                pc <= offset;
                                step <= 3'h0;
                                state <= ST_PUSH;
                                busy <= 1'b1;
                            end
                            `CPRS_OP_RTS, `CPRS_OP_RTI:
                            begin
                                frame_len <= (op == `CPRS_OP_RTI) ? `CPRS_INT_FRAME : `CPRS_CALL_FRAME;
                                step <= 3'h0;
                                state <= ST_POPREQ;
                                busy <= 1'b1;
                            end
                            `CPRS_OP_SWI:
                            begin
                                seq_int <= 1'b1;
                                frame_len <= `CPRS_INT_FRAME;
                                seq_target <= swi_vector;
                                step <= 3'h0;
                                state <= ST_PUSH;
                                busy <= 1'b1;
                            end
                            default: ;
                        endcase
                    end
                    else if (instr_done && (nmi_pend || irq_allowed))
                    begin
                        // Non-maskable source ignores the mask and wins the tie
                        if (nmi_pend)
                        begin
                            nmi_pend <= nmi_in;
                            seq_target <= nmi_vector;
                        end
                        else
                        begin
                            irq_pend <= irq_in;
                            seq_target <= irq_vector;
                        end
                        seq_int <= 1'b1;
                        frame_len <= `CPRS_INT_FRAME;
                        step <= 3'h0;
                        state <= ST_PUSH;
                        busy <= 1'b1;
                    end
                end
                ST_PUSH:
                begin
                    // Write at the free slot, then move down
                    stk_addr <= sp;
                    stk_wdata <= push_byte;
                    stk_we <= 1'b1;
                    sp <= sp_dec;
                    step <= step + 3'h1;
                    if (last_step)
                    begin
                        if (seq_int)
                        begin
                            flags[`CPRS_FLG_I] <= 1'b1;
                            pc <= seq_target;
                        end
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        seq_done <= 1'b1;
                    end
                end
                ST_POPREQ:
                begin
                    // Move up first, then read the slot
                    sp <= sp_inc;
                    stk_addr <= sp_inc;
                    stk_re <= 1'b1;
                    state <= ST_POPCAP;
                end
                ST_POPCAP:
                begin
                    case (pop_slot)
                        3'h0: pc[7:0] <= stk_rdata;
                        3'h1: pc[15:8] <= stk_rdata;
                        3'h2: page_base <= stk_rdata;
                        3'h3: idx <= stk_rdata;
                        3'h4: acc <= stk_rdata;
                        default: flags <= stk_rdata[4:0];
                    endcase
                    step <= step + 3'h1;
                    if (last_step)
                    begin
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        seq_done <= 1'b1;
                    end
                    else
                        state <= ST_POPREQ;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule

// ### verif/cprs_top_checker.sv
// Checker for cprs_top: address forming, stack stepping and frame shape.
// Assumes it is bound onto cprs_top and that clk_sys is the only clock.
`timescale 1ns/1ps
`include "cprs_map.vh"
module cprs_top_checker (
    input wire clk_sys,
    input wire rst_n,
    input wire op_valid,
    input wire [3:0] op,
    input wire [7:0] operand,
    input wire [15:0] offset,
    input wire [1:0] ea_mode,
    input wire rm_instr,
    input wire stk_we,
    input wire stk_re,
    input wire [15:0] stk_addr,
    input wire [7:0] stk_wdata,
    input wire [7:0] acc,
    input wire [7:0] idx,
    input wire [15:0] pc,
    input wire [15:0] sp,
    input wire [7:0] page_base,
    input wire [4:0] flags,
    input wire [15:0] ea,
    input wire busy
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Wrap keeps the pointer inside the window even on overflow
    property p_sp_window;
        sp >= `CPRS_SP_LOW && sp <= `CPRS_SP_TOP;
    endproperty
    a_sp_window: assert property (p_sp_window) else $error("sp left window");

    property p_idx_ea;
        ea_mode == `CPRS_EA_INDEXED |=> ea == $past(offset) + {8'h00, $past(idx)};
    endproperty
    a_idx_ea: assert property (p_idx_ea) else $error("indexed ea wrong");

    property p_dir_ea;
        ea_mode == `CPRS_EA_DIRECT && !rm_instr |=> ea == {$past(page_base), $past(operand)};
    endproperty
    a_dir_ea: assert property (p_dir_ea) else $error("direct ea wrong");

    property p_push_step;
        stk_we && $past(stk_we) && $past(stk_addr) != `CPRS_SP_LOW |-> stk_addr == $past(stk_addr) - 16'h0001;
    endproperty
    a_push_step: assert property (p_push_step) else $error("push step wrong");

    property p_pop_step;
        stk_re ##2 (stk_re && $past(stk_addr, 2) != `CPRS_SP_TOP) |-> stk_addr == $past(stk_addr, 2) + 16'h0001;
    endproperty
    a_pop_step: assert property (p_pop_step) else $error("pop step wrong");

    property p_call_frame;
        op_valid && !busy && op == `CPRS_OP_CALL |=> (busy && !stk_we) ##1 (busy && stk_we)[*2]
            ##1 (!busy && stk_we) ##1 !stk_we;
    endproperty
    a_call_frame: assert property (p_call_frame) else $error("call frame length wrong");

    property p_call_data;
        op_valid && !busy && op == `CPRS_OP_CALL |=> ##1 {8'h00, stk_wdata} == ($past(pc, 2) & 16'h00ff)
            ##1 {8'h00, stk_wdata} == ($past(pc, 3) >> 8) ##1 stk_wdata == $past(page_base, 4);
    endproperty
    a_call_data: assert property (p_call_data) else $error("call push order wrong");

    property p_lda;
        op_valid && !busy && op == `CPRS_OP_LDA |=> acc == $past(operand)
            && flags[`CPRS_FLG_N] == acc[7] && flags[`CPRS_FLG_Z] == (acc == 8'h00);
    endproperty
    a_lda: assert property (p_lda) else $error("load flags wrong");
endmodule

bind cprs_top cprs_top_checker cprs_top_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op(op), .operand(operand),
    .offset(offset), .ea_mode(ea_mode), .rm_instr(rm_instr), .stk_we(stk_we), .stk_re(stk_re),
    .stk_addr(stk_addr), .stk_wdata(stk_wdata), .acc(acc), .idx(idx), .pc(pc), .sp(sp),
    .page_base(page_base), .flags(flags), .ea(ea), .busy(busy)
);

// ### verif/cprs_top_tb.sv
// Testbench for cprs_top: commands, bus, interrupts and stack frames.
// Assumes a one-cycle stack RAM, modelled here, on the stack port.
`timescale 1ns/1ps
`include "cprs_map.vh"
module cprs_top_tb;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg op_valid = 1'b0, rm_instr = 1'b0, pc_inc = 1'b0, instr_done = 1'b0;
    reg irq_in = 1'b0, nmi_in = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    reg [3:0] op = 4'h0;
    reg [2:0] alu_fn = 3'h0;
    reg [7:0] operand = 8'h00, bus_wdata = 8'h00;
    reg [15:0] offset = 16'h0000, bus_addr = 16'h0000;
    reg [1:0] ea_mode = 2'h0;
    wire [7:0] bus_rdata, stk_wdata, acc, idx, page_base;
    wire [15:0] stk_addr, pc, sp, ea;
    wire [4:0] flags;
    wire bus_ack, stk_we, stk_re, busy, seq_done;
    reg [7:0] ram [0:511];
    reg [15:0] wq [$];
    int fails = 0;
    int samples_checked = 0;
    // Released data line shows the inverse so stale data cannot pass
    wire [7:0] stk_rdata = stk_re ? ram[stk_addr[8:0]] : ~ram[stk_addr[8:0]];

    cprs_top cprs_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op(op),
        .alu_fn(alu_fn), .operand(operand), .offset(offset), .ea_mode(ea_mode), .rm_instr(rm_instr),
        .pc_inc(pc_inc), .instr_done(instr_done), .irq_in(irq_in), .nmi_in(nmi_in),
        .irq_vector(16'h3000), .nmi_vector(16'h4000), .swi_vector(16'h5000), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .stk_rdata(stk_rdata), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
        .stk_we(stk_we), .stk_re(stk_re), .acc(acc), .idx(idx), .pc(pc), .sp(sp),
        .page_base(page_base), .flags(flags), .ea(ea), .busy(busy), .seq_done(seq_done));

    // Clock and stack RAM; every push is also logged as {addr low, data}
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        if (stk_we)
        begin
            ram[stk_addr[8:0]] <= stk_wdata;
            wq.push_back({stk_addr[7:0], stk_wdata});
        end
    end

    task chk(input [8*8-1:0] nm, input [15:0] e, input [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %0s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bounded wait for the end of a frame
    task idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 40)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk("idle", 16'h0000, {15'h0000, busy});
        if (n > 0)
            chk("done", 16'h0001, {15'h0000, seq_done});
        // One more cycle so the RAM model logs the final push
        @(negedge clk_sys);
    endtask

    task cmd(input [3:0] c, input [2:0] f, input [7:0] d, input [15:0] o);
        @(negedge clk_sys);
        op_valid = 1'b1;
        op = c;
        alu_fn = f;
        operand = d;
        offset = o;
        @(negedge clk_sys);
        op_valid = 1'b0;
        idle;
    endtask

    // One-cycle strobe: 0 pc_inc, 1 irq_in, 2 nmi_in, 3 instr_done
    task pulse(input [1:0] w);
        @(negedge clk_sys);
        {instr_done, nmi_in, irq_in, pc_inc} = 4'b0001 << w;
        @(negedge clk_sys);
        {instr_done, nmi_in, irq_in, pc_inc} = 4'h0;
        idle;
    endtask

    task bwr(input [15:0] a, input [7:0] d);
        @(negedge clk_sys);
        bus_wr = 1'b1;
        bus_addr = a;
        bus_wdata = d;
        @(negedge clk_sys);
        bus_wr = 1'b0;
    endtask

    task brd(input [15:0] a, input [7:0] e);
        @(negedge clk_sys);
        bus_rd = 1'b1;
        bus_addr = a;
        @(negedge clk_sys);
        bus_rd = 1'b0;
        chk("ack", 16'h0001, {15'h0000, bus_ack});
        chk("rdata", {8'h00, e}, {8'h00, bus_rdata});
    endtask

    // Compares the logged pushes; addresses fall from 017f
    task chk_frame(input [47:0] ed, input int n);
        chk("pushes", n[15:0], wq.size());
        for (int i = 0; i < n; i++)
            chk("push", {8'h7f - i[7:0], ed[47 - 8 * i -: 8]}, wq[i]);
        wq.delete();
    endtask

    task t_reset;
        chk("acc", 16'h0000, {8'h00, acc});
        chk("pc", `CPRS_PC_RESET, pc);
        chk("sp", `CPRS_SP_TOP, sp);
        chk("page", 16'h0000, {8'h00, page_base});
        chk("flags", 16'h0008, {11'h000, flags});
        $display("reset values done");
    endtask

    task t_data;
        cmd(`CPRS_OP_LDA, 3'h0, 8'h80, 16'h0);
        chk("flags", 16'h000c, {11'h000, flags});
        cmd(`CPRS_OP_LDA, 3'h0, 8'h00, 16'h0);
        chk("flags", 16'h000a, {11'h000, flags});
        cmd(`CPRS_OP_LDA, 3'h0, 8'h0f, 16'h0);
        cmd(`CPRS_OP_ALU_A, `CPRS_FN_ADD, 8'h01, 16'h0);
        chk("flags", 16'h0018, {11'h000, flags});
        cmd(`CPRS_OP_ALU_A, `CPRS_FN_ADD, 8'hf0, 16'h0);
        chk("flags", 16'h000b, {11'h000, flags});
        cmd(`CPRS_OP_ALU_A, `CPRS_FN_SUB, 8'h01, 16'h0);
        chk("acc", 16'h00ff, {8'h00, acc});
        chk("flags", 16'h000d, {11'h000, flags});
        cmd(`CPRS_OP_LDX, 3'h0, 8'h05, 16'h0);
        cmd(`CPRS_OP_ALU_X, `CPRS_FN_ADD, 8'h03, 16'h0);
        chk("idx", 16'h0008, {8'h00, idx});
        cmd(`CPRS_OP_BTB, 3'h3, 8'h08, 16'h0);
        chk("carry", 16'h0001, {15'h0000, flags[`CPRS_FLG_C]});
        cmd(`CPRS_OP_BTB, 3'h2, 8'h08, 16'h0);
        chk("carry", 16'h0000, {15'h0000, flags[`CPRS_FLG_C]});
        $display("data and flags done");
    endtask

    task t_addr;
        bwr(16'h003e, 8'hff);
        bwr(`CPRS_PAGE_BASE_ADDR, 8'h5a);
        brd(`CPRS_PAGE_BASE_ADDR, 8'h5a);
        brd(16'h003e, 8'h00);
        @(negedge clk_sys);
        ea_mode = `CPRS_EA_INDEXED;
        offset = 16'h0100;
        @(negedge clk_sys);
        chk("ea", 16'h0108, ea);
        ea_mode = `CPRS_EA_DIRECT;
        operand = 8'h34;
        @(negedge clk_sys);
        chk("ea", 16'h5a34, ea);
        rm_instr = 1'b1;
        @(negedge clk_sys);
        chk("ea", 16'h0034, ea);
        ea_mode = `CPRS_EA_NONE;
        rm_instr = 1'b0;
        $display("addressing done");
    endtask

    task t_call;
        cmd(`CPRS_OP_JMP, 3'h0, 8'h00, 16'h1234);
        pulse(2'h0);
        chk("pc", 16'h1235, pc);
        wq.delete();
        cmd(`CPRS_OP_CALL, 3'h0, 8'h00, 16'h2000);
        chk_frame({8'h35, 8'h12, 8'h5a, 24'h0}, 3);
        chk("sp", 16'h017c, sp);
        chk("pc", 16'h2000, pc);
        bwr(`CPRS_PAGE_BASE_ADDR, 8'h00);
        cmd(`CPRS_OP_RTS, 3'h0, 8'h00, 16'h0);
        chk("pc", 16'h1235, pc);
        chk("page", 16'h005a, {8'h00, page_base});
        chk("sp", 16'h017f, sp);
        $display("call and return done");
    endtask

    task t_irq;
        cmd(`CPRS_OP_LDCC, 3'h0, 8'h08, 16'h0);
        pulse(2'h1);
        pulse(2'h3);
        chk("pc", 16'h1235, pc);
        cmd(`CPRS_OP_CLI, 3'h0, 8'h00, 16'h0);
        pulse(2'h3);
        chk("pc", 16'h1235, pc);
        wq.delete();
        pulse(2'h3);
        chk_frame({8'h35, 8'h12, 8'h5a, 8'h08, 8'hff, 8'he0}, 6);
        chk("pc", 16'h3000, pc);
        chk("flags", 16'h0008, {11'h000, flags});
        cmd(`CPRS_OP_LDA, 3'h0, 8'h00, 16'h0);
        cmd(`CPRS_OP_RTI, 3'h0, 8'h00, 16'h0);
        chk("acc", 16'h00ff, {8'h00, acc});
        chk("flags", 16'h0000, {11'h000, flags});
        chk("sp", 16'h017f, sp);
        cmd(`CPRS_OP_LDCC, 3'h0, 8'h08, 16'h0);
        pulse(2'h2);
        pulse(2'h3);
        chk("pc", 16'h4000, pc);
        cmd(`CPRS_OP_RSP, 3'h0, 8'h00, 16'h0);
        chk("sp", `CPRS_SP_TOP, sp);
        $display("interrupts done");
    endtask

    task t_nest;
        repeat (42) cmd(`CPRS_OP_CALL, 3'h0, 8'h00, 16'h2000);
        chk("sp", `CPRS_SP_LOW, sp);
        cmd(`CPRS_OP_RSP, 3'h0, 8'h00, 16'h0);
        chk("sp", `CPRS_SP_TOP, sp);
        $display("nesting done");
    endtask

    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence; first command waits out the two-flop release
    initial
    begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_reset;
        t_data;
        t_addr;
        t_call;
        t_irq;
        t_nest;
        print_verdict;
    end

    // Watchdog: the run needs about 400 cycles
    initial
    begin
        #50000;
        fails++;
        print_verdict;
    end
endmodule
